/* File: hdl/tlb_readout_pkg.sv */
/*
  Constants for the walk-unit translation cache readout path: register
  offsets, pointer field layout, readout word layout and bus response codes.
  Assumes a single system clock domain shared by every user of the package.
*/
package tlb_readout_pkg;

  // register offsets within the global register space
  localparam logic [11:0] PTR_OFFSET = 12'h088;
  localparam logic [11:0] DATA_OFFSET = 12'h08C;

  // pointer register field layout
  localparam int SRC_HI = 27;
  localparam int SRC_LO = 26;
  localparam int WAY_HI = 25;
  localparam int WAY_LO = 24;
  localparam int ENTRY_HI = 15;
  localparam int ENTRY_LO = 4;
  localparam int WORD_HI = 3;
  localparam int WORD_LO = 2;
  localparam int PTR_LOW_HI = 15;
  localparam logic [15:0] PTR_STEP = 16'h0004;
  localparam logic [31:0] PTR_WRITE_MASK = 32'h0FFF_FFFC;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;

  localparam logic [1:0] SRC_MAIN_CACHE = 2'h0;
  localparam logic [1:0] SRC_PREFETCH = 2'h1;
  localparam logic [1:0] SRC_IPA_CACHE = 2'h2;
  localparam logic [1:0] SRC_WALK_CACHE = 2'h3;

  // readout word layout
  localparam int VA_WIDTH = 37;
  localparam int VA0_WIDTH = 28;
  localparam int VA1_WIDTH = 9;
  localparam int ASID_WIDTH = 16;
  localparam int PAYLOAD_WIDTH = 28;
  localparam logic [1:0] POS_MIDDLE = 2'h0;
  localparam logic [1:0] POS_ENTRY_FIRST = 2'h1;
  localparam logic [1:0] POS_ENTRY_LAST = 2'h2;
  localparam logic [1:0] POS_CACHE_FIRST = 2'h3;
  localparam logic [1:0] WORD_0 = 2'h0;
  localparam logic [1:0] WORD_1 = 2'h1;
  localparam logic [1:0] WORD_LAST = 2'h3;

  // bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int PROT_NONSECURE = 1;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

/* File: hdl/readout_word_format.sv */
/*
  Builds one 32-bit readout word from the fields returned by the cache.
  Purely combinational; assumes its caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none

module readout_word_format
  import tlb_readout_pkg::*;
(
  input wire logic [1:0] i_word_sel,
  input wire logic i_entry_zero,
  input wire logic i_pointer_invalid,
  input wire logic i_word_invalid,
  input wire logic [VA_WIDTH-1:0] i_lookup_va,
  input wire logic [ASID_WIDTH-1:0] i_asid,
  input wire logic i_nonsecure_state_bit,
  input wire logic [1:0] i_entry_type,
  input wire logic [PAYLOAD_WIDTH-1:0] i_payload,
  output logic [31:0] o_word
);

  logic [1:0] entry_word_position;
  logic [3:0] status_bits;

  always_comb begin
    if (i_word_sel == WORD_0 && i_entry_zero) begin
      entry_word_position = POS_CACHE_FIRST;
    end else if (i_word_sel == WORD_0) begin
      entry_word_position = POS_ENTRY_FIRST;
    end else if (i_word_sel == WORD_LAST) begin
      entry_word_position = POS_ENTRY_LAST;
    end else begin
      entry_word_position = POS_MIDDLE;
    end
  end

  // same low nibble on every word
  assign status_bits = {entry_word_position, i_pointer_invalid, i_word_invalid};

  always_comb begin
    case (i_word_sel)
      WORD_0: begin
        o_word = {i_lookup_va[VA_WIDTH-1:VA1_WIDTH], status_bits};
      end
      WORD_1: begin
        o_word = {i_asid, i_nonsecure_state_bit, i_entry_type,
                  i_lookup_va[VA1_WIDTH-1:0], status_bits};
      end
      default: begin
        o_word = {i_payload, status_bits};
      end
    endcase
  end

endmodule // readout_word_format

`default_nettype wire

/* File: hdl/tlb_debug_readout.sv */
/*
  Walk-unit translation cache readout: pointer register and readout data
  register behind an AXI4-Lite style programming port, and a request/ack
  port toward the cache storage that returns one entry's fields.
  Assumes bus and cache logic run on i_clk; no synchronisers are needed.
*/
//
// Overview of operation
// - pointer bits 31:28 always read zero; bits 27:16 read zero unless software wrote ones there.
// - bits 27:26 pick main cache, prefetch buffer, IPA cache or walk cache.
// - bits 25:24 pick one of four ways, reset to 00.
// - bits 15:4 hold the entry index, reset to zero.
// - bits 3:2 hold the word offset in the entry, reset to zero.
// - word 0 carries the lookup virtual address in bits 31:4.
// - bits 3:2 give middle, entry-first, entry-last or cache-first word.
// - bit 1 is set when the programmed pointer is invalid.
// - bit 0 is set when the returned word information is invalid.
// - word 1 carries address space id in 31:16, non-secure flag in 15.
// - word 1 bits 14:13 carry the entry type encoding.
// - word 1 bits 12:4 carry nine more lookup address bits.
// - word 1 low nibble repeats position and validity flags.
// - each secure in-bounds data read returns the addressed word then advances one word, unless a secure pointer write fires in the ack cycle.
// - pointer bits 1:0 read zero and ignore writes.
// - data read with an out-of-bounds pointer ends with SLVERR.
// - only secure transactions may reach the pointer and data registers.
`timescale 1ns/1ps
`default_nettype none

module tlb_debug_readout
  import tlb_readout_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int NUM_ENTRIES = 4096
)(
  input wire logic i_clk,
  input wire logic i_arst_n,
  // write address / data / response
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_WIDTH-1:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // read address / data
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_WIDTH-1:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // cache storage read port
  output logic o_cache_req,
  output logic [1:0] o_readout_source_select,
  output logic [1:0] o_cache_way,
  output logic [11:0] o_cache_entry,
  output logic [1:0] o_cache_word,
  input wire logic i_cache_ack,
  input wire logic [VA_WIDTH-1:0] i_cache_lookup_va,
  input wire logic [ASID_WIDTH-1:0] i_cache_asid,
  input wire logic i_cache_nonsecure_state_bit,
  input wire logic [1:0] i_cache_entry_type,
  input wire logic [PAYLOAD_WIDTH-1:0] i_cache_payload,
  input wire logic i_cache_word_invalid
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RESPOND} read_state_type;

  read_state_type state_ff;
  logic [31:0] pointer_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic wr_secure;
  logic rd_fire;
  logic rd_secure;
  logic [31:0] byte_mask;
  logic [31:0] nxt_pointer;
  logic pointer_out_of_bounds;
  logic [31:0] formatted_word;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes

  // write needs both channels together; no buffering of a lone address
  assign wr_fire = i_s_axi_awvalid && i_s_axi_wvalid && !bvalid_ff;
  assign o_s_axi_awready = i_s_axi_awvalid && i_s_axi_wvalid && !bvalid_ff;
  assign o_s_axi_wready = i_s_axi_awvalid && i_s_axi_wvalid && !bvalid_ff;
  assign wr_secure = !i_s_axi_awprot[PROT_NONSECURE];
  assign rd_fire = i_s_axi_arvalid && (state_ff == ST_IDLE);
  assign o_s_axi_arready = (state_ff == ST_IDLE);
  assign rd_secure = !i_s_axi_arprot[PROT_NONSECURE];
  assign o_s_axi_rvalid = (state_ff == ST_RESPOND);
  assign o_s_axi_rdata = rdata_ff;
  assign o_s_axi_rresp = rresp_ff;
  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp = bresp_ff;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byte_mask[b*8 +: 8] = {8{i_s_axi_wstrb[b]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer register

  assign pointer_out_of_bounds = (32'(pointer_ff[ENTRY_HI:ENTRY_LO]) >= 32'(NUM_ENTRIES));

  always_comb begin
    nxt_pointer = pointer_ff;
    if (wr_fire && wr_secure && i_s_axi_awaddr == ADDR_WIDTH'(PTR_OFFSET)) begin
      nxt_pointer = ((pointer_ff & ~byte_mask) | (i_s_axi_wdata & byte_mask))
                    & PTR_WRITE_MASK;
    end else if (state_ff == ST_FETCH && i_cache_ack) begin
      // step carries from the word field into the entry field
      nxt_pointer[PTR_LOW_HI:0] = pointer_ff[PTR_LOW_HI:0] + PTR_STEP;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pointer_ff <= PTR_RESET;
    end else begin
      pointer_ff <= nxt_pointer;
    end
  end

  assign o_readout_source_select = pointer_ff[SRC_HI:SRC_LO];
  assign o_cache_way = pointer_ff[WAY_HI:WAY_LO];
  assign o_cache_entry = pointer_ff[ENTRY_HI:ENTRY_LO];
  assign o_cache_word = pointer_ff[WORD_HI:WORD_LO];
  assign o_cache_req = (state_ff == ST_FETCH);

  ////////////////////////////////////////////////////////////////////////////
  // write response

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      if (i_s_axi_awaddr != ADDR_WIDTH'(PTR_OFFSET) && i_s_axi_awaddr != ADDR_WIDTH'(DATA_OFFSET)) begin
        bresp_ff <= RESP_DECERR;
      end else if (!wr_secure) begin
        bresp_ff <= RESP_SLVERR;
      end else if (i_s_axi_awaddr == ADDR_WIDTH'(DATA_OFFSET)) begin
        bresp_ff <= RESP_SLVERR; // data register is read-only
      end else begin
        bresp_ff <= RESP_OKAY;
      end
    end else if (i_s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  readout_word_format u_format (
    .i_word_sel(pointer_ff[WORD_HI:WORD_LO]),
    .i_entry_zero(pointer_ff[ENTRY_HI:ENTRY_LO] == '0),
    .i_pointer_invalid(pointer_out_of_bounds),
    .i_word_invalid(i_cache_word_invalid),
    .i_lookup_va(i_cache_lookup_va),
    .i_asid(i_cache_asid),
    .i_nonsecure_state_bit(i_cache_nonsecure_state_bit),
    .i_entry_type(i_cache_entry_type),
    .i_payload(i_cache_payload),
    .o_word(formatted_word)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= ST_IDLE;
      rdata_ff <= ZERO_WORD;
      rresp_ff <= RESP_OKAY;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (rd_fire) begin
            rdata_ff <= ZERO_WORD;
            rresp_ff <= RESP_OKAY;
            if (i_s_axi_araddr == ADDR_WIDTH'(PTR_OFFSET) && rd_secure) begin
              rdata_ff <= pointer_ff;
              state_ff <= ST_RESPOND;
            end else if (i_s_axi_araddr == ADDR_WIDTH'(PTR_OFFSET)) begin
              rresp_ff <= RESP_SLVERR;
              state_ff <= ST_RESPOND;
            end else if (i_s_axi_araddr == ADDR_WIDTH'(DATA_OFFSET) && !rd_secure) begin
              rresp_ff <= RESP_SLVERR;
              state_ff <= ST_RESPOND;
            end else if (i_s_axi_araddr == ADDR_WIDTH'(DATA_OFFSET)
                         && pointer_out_of_bounds) begin
              // no fetch and no advance, so software sees the bad pointer
              rdata_ff <= {28'h000_0000, POS_MIDDLE, 1'b1, 1'b1};
              rresp_ff <= RESP_SLVERR;
              state_ff <= ST_RESPOND;
            end else if (i_s_axi_araddr == ADDR_WIDTH'(DATA_OFFSET)) begin
              state_ff <= ST_FETCH;
            end else begin
              rresp_ff <= RESP_DECERR;
              state_ff <= ST_RESPOND;
            end
          end
        end
        ST_FETCH: begin
          if (i_cache_ack) begin
            rdata_ff <= formatted_word;
            state_ff <= ST_RESPOND;
          end
        end
        ST_RESPOND: begin
          if (i_s_axi_rready) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // tlb_debug_readout

`default_nettype wire

/* File: test/tlb_debug_readout_monitor.sv */
/*
  Concurrent checks for tlb_debug_readout, bound to the top module.
  Assumes one clock domain and that it sees the top module's ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module tlb_debug_readout_monitor
  import tlb_readout_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [2:0] i_s_axi_arprot,
  input wire logic o_s_axi_awready,
  input wire logic o_s_axi_rvalid,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_cache_req,
  input wire logic [1:0] o_readout_source_select,
  input wire logic [1:0] o_cache_way,
  input wire logic [11:0] o_cache_entry,
  input wire logic [1:0] o_cache_word,
  input wire logic i_cache_ack,
  input wire logic [VA_WIDTH-1:0] i_cache_lookup_va,
  input wire logic [ASID_WIDTH-1:0] i_cache_asid,
  input wire logic i_cache_nonsecure_state_bit,
  input wire logic [1:0] i_cache_entry_type,
  input wire logic i_cache_word_invalid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////////////
  logic fetch_done;
  logic [1:0] exp_pos;
  logic [27:0] exp_hi;
  logic [13:0] word_idx;
  assign fetch_done = o_cache_req && i_cache_ack;
  assign word_idx = {o_cache_entry, o_cache_word};
  assign exp_pos = (o_cache_word == WORD_0) ? ((o_cache_entry == 12'h000) ? 2'h3 : 2'h1)
                 : ((o_cache_word == WORD_LAST) ? 2'h2 : 2'h0);
  assign exp_hi = (o_cache_word == WORD_0) ? i_cache_lookup_va[36:9] : {i_cache_asid,
                  i_cache_nonsecure_state_bit, i_cache_entry_type, i_cache_lookup_va[8:0]};
  ////////////////////////////////////////////////////////////////////////////
  a_fetch_fields_held: assert property (o_cache_req && !i_cache_ack |=> o_cache_req &&
    $stable({o_readout_source_select, o_cache_way, word_idx})) else $error("fetch fields moved");
  a_fetch_answered: assert property (fetch_done |=> o_s_axi_rvalid &&
    o_s_axi_rresp == RESP_OKAY) else $error("fetch not answered");
  a_ack_ends_req: assert property (fetch_done |=> !o_cache_req) else $error("req after ack");
  a_word_flags: assert property (fetch_done |=> o_s_axi_rdata[1:0] ==
    {1'b0, $past(i_cache_word_invalid)}) else $error("validity flags wrong");
  a_word_position: assert property (fetch_done |=> o_s_axi_rdata[3:2] == $past(exp_pos))
    else $error("position code wrong");
  a_word_payload: assert property (fetch_done && o_cache_word <= WORD_1 |=>
    o_s_axi_rdata[31:4] == $past(exp_hi)) else $error("word payload wrong");
  a_pointer_advance: assert property (fetch_done && !o_s_axi_awready |=>
    word_idx == $past(word_idx) + 14'h1 && $stable({o_readout_source_select, o_cache_way}))
    else $error("pointer did not advance one word");
  a_nonsecure_refused: assert property (i_s_axi_arvalid && o_s_axi_arready &&
    i_s_axi_arprot[1] |=> !o_cache_req && o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR &&
    o_s_axi_rdata == ZERO_WORD) else $error("nonsecure read not refused");
  c_last_word: cover property (fetch_done && o_cache_word == WORD_LAST);
  c_cache_first: cover property (fetch_done && exp_pos == POS_CACHE_FIRST);
  c_slverr: cover property (o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR);
endmodule // tlb_debug_readout_monitor

bind tlb_debug_readout tlb_debug_readout_monitor u_tlb_debug_readout_monitor (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .i_s_axi_arprot(i_s_axi_arprot),
  .o_s_axi_awready(o_s_axi_awready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp), .o_cache_req(o_cache_req),
  .o_readout_source_select(o_readout_source_select), .o_cache_way(o_cache_way),
  .o_cache_entry(o_cache_entry), .o_cache_word(o_cache_word), .i_cache_ack(i_cache_ack),
  .i_cache_lookup_va(i_cache_lookup_va), .i_cache_asid(i_cache_asid),
  .i_cache_nonsecure_state_bit(i_cache_nonsecure_state_bit),
  .i_cache_entry_type(i_cache_entry_type), .i_cache_word_invalid(i_cache_word_invalid));
`default_nettype wire

/* File: test/tlb_debug_readout_tb.sv */
/*
  Self-checking bench for tlb_debug_readout: pointer access, random cache
  fields and pointers, refusals. Assumes the checker binds itself.
*/
`timescale 1ns/1ps
`default_nettype none

module tlb_debug_readout_tb;
  import tlb_readout_pkg::*;
  logic i_clk, i_arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ack = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] seed = 32'h0000_23D4, wdata = 32'h0, exp_data, d, p, q;
  logic [63:0] t = 64'h0, f;
  logic [15:0] lo;
  logic [1:0] r, wait_cnt = 2'h0;
  wire logic awready, wready, bvalid, arready, rvalid, req;
  wire logic [1:0] bresp, rresp, src, way, word;
  wire logic [31:0] rdata;
  wire logic [11:0] entry;
  int n_fail, tests_run, cycles;

  // small bound so the out-of-range refusal can be reached
  tlb_debug_readout #(.NUM_ENTRIES(16)) u_tlb_debug_readout (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(awprot), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
    .i_s_axi_arprot(arprot), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_cache_req(req),
    .o_readout_source_select(src), .o_cache_way(way), .o_cache_entry(entry),
    .o_cache_word(word), .i_cache_ack(ack), .i_cache_lookup_va(t[36:0]),
    .i_cache_asid(t[52:37]), .i_cache_nonsecure_state_bit(t[53]),
    .i_cache_entry_type(t[55:54]), .i_cache_payload({t[63:57], t[20:0]}),
    .i_cache_word_invalid(t[56]));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] exp_word(logic [1:0] w, logic [11:0] e, logic [63:0] f);
    logic [3:0] nib;
    nib = {(w == 2'h0) ? ((e == 12'h000) ? 2'h3 : 2'h1) : ((w == 2'h3) ? 2'h2 : 2'h0), 1'b0, f[56]};
    if (w == 2'h0) return {f[36:9], nib};
    if (w == 2'h1) return {f[52:37], f[53], f[55:54], f[8:0], nib};
    return {f[63:57], f[20:0], nib};
  endfunction

  // cache fields change every cycle; only the ack cycle carries meaning
  // one draw per cycle, so the expected word sees exactly the fields the ack cycle carries
  always @(posedge i_clk) begin
    f = {rnd(), rnd()};
    t <= f;
    if (req && !ack && wait_cnt == 2'h0) begin
      ack <= 1'b1; // bench only compares readout words, never acts on them
      wait_cnt <= f[1:0];
      exp_data <= exp_word(word, entry, f);
    end else begin
      ack <= 1'b0;
      if (req && !ack) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [2:0] pr);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    awprot <= pr;
    do @(posedge i_clk); while (!awready);
    chk("write ready", 32'h0000_0001, 32'(wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge i_clk); while (!bvalid);
    r = bresp;
  endtask

  task automatic rd(input logic [11:0] a, input logic [2:0] pr);
    arvalid <= 1'b1;
    araddr <= a;
    arprot <= pr;
    do @(posedge i_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge i_clk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    rd(PTR_OFFSET, 3'h0);
    chk("pointer reset", PTR_RESET, d);
    wr(PTR_OFFSET, 32'hFFFF_FFFF, 3'h0);
    rd(PTR_OFFSET, 3'h0);
    chk("pointer mask", 32'h0FFF_FFFC, d);
    chk("source and way", 32'h0000_000F, {28'h0, src, way});
    rd(DATA_OFFSET, 3'h0);
    chk("bound resp", 32'(RESP_SLVERR), 32'(r));
    chk("bound data", 32'h0000_0003, d);
    for (int s = 0; s < 4; s++) begin
      q = rnd();
      lo = (s == 0) ? 16'h0000 : {8'h00, 4'(q[5:2] % 4'hD), q[7:6], 2'b00};
      p = {4'h0, s[1:0], q[1:0], 8'h00, lo};
      wr(PTR_OFFSET, p, 3'h0);
      for (int k = 0; k < 6; k++) begin
        rd(DATA_OFFSET, 3'h0);
        chk("readout word", exp_data, d);
      end
      rd(PTR_OFFSET, 3'h0);
      chk("pointer advance", p + 32'h0000_0018, d);
    end
    wr(PTR_OFFSET, 32'h0000_0010, 3'h2);
    chk("nonsecure write", 32'(RESP_SLVERR), 32'(r));
    rd(PTR_OFFSET, 3'h0);
    chk("pointer kept", p + 32'h0000_0018, d);
    rd(DATA_OFFSET, 3'h2);
    chk("nonsecure read", 32'(RESP_SLVERR), 32'(r));
    chk("nonsecure data", ZERO_WORD, d);
    wr(DATA_OFFSET, 32'h0000_0000, 3'h0);
    chk("data write", 32'(RESP_SLVERR), 32'(r));
    rd(12'h100, 3'h0);
    chk("unmapped read", 32'(RESP_DECERR), 32'(r));
    chk("unmapped data", ZERO_WORD, d);
    complete_run();
  end
endmodule // tlb_debug_readout_tb
`default_nettype wire
